// File: logic/mid_pkg.sv
/*
 Package for the interrupt dispatch block: register addresses, reset values,
 source layout, timing counts and carrier structs.
 Assumes an 8-bit special register port driven by the core, one clock domain.
*/
package mid_pkg;

    localparam int          NUM_SRC        = 15;
    localparam int          SRC_W          = 4;

    localparam logic [7:0]  ADDR_EN_MAIN   = 8'ha8;
    localparam logic [7:0]  ADDR_PRI_MAIN  = 8'hb8;
    localparam logic [7:0]  ADDR_EXT_CFG   = 8'he4;
    localparam logic [7:0]  ADDR_EN_EXT1   = 8'he6;
    localparam logic [7:0]  ADDR_EN_EXT2   = 8'he7;
    localparam logic [7:0]  ADDR_PRI_EXT1  = 8'hf3;
    localparam logic [7:0]  ADDR_PRI_EXT2  = 8'hf4;
    localparam logic [7:0]  ADDR_PEND_LO   = 8'he2;
    localparam logic [7:0]  ADDR_PEND_HI   = 8'he3;
    localparam logic [7:0]  ADDR_ACTIVE    = 8'hf5;

    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam int          GLOBAL_EN_BIT  = 7;
    localparam int          MAIN_SRC_CNT   = 7;
    localparam int          EXT1_SRC_CNT   = 6;
    localparam int          EXT2_SRC_CNT   = 2;

    // sources cleared by hardware on vectoring: the two pin sources and timers 0, 1
    localparam logic [14:0] AUTO_CLR_MASK  = 15'h000f;

    localparam int          DETECT_CYC     = 1;
    localparam int          CALL_CYC       = 4;
    localparam logic [2:0]  CALL_CNT       = 3'(CALL_CYC - 1);

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mid_sfr_req_s;

    typedef struct packed {
        logic             valid;
        logic             high;
        logic [SRC_W-1:0] src;
    } mid_req_s;

    typedef enum logic [1:0] {
        MID_IDLE,
        MID_WAIT_INSN,
        MID_CALL,
        MID_HOLD
    } mid_state_e;

endpackage

// File: logic/mid_arbiter.sv
/*
 Fixed-order priority arbiter for the dispatch block.
 Assumes the eligible vector is already gated by enables and the preemption
 level; purely combinational.
*/
module mid_arbiter
    import mid_pkg::*;
#(
    parameter int N = NUM_SRC
)(
    input  wire logic [N-1:0] elig_i,
    input  wire logic [N-1:0] prio_i,
    output mid_req_s          pick_o
);

    function automatic logic [SRC_W:0] first_set(input logic [N-1:0] v);
        first_set = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = {1'b1, SRC_W'(i)};
            end
        end
    endfunction

    logic [SRC_W:0] hi_pick;
    logic [SRC_W:0] lo_pick;

    always_comb
    begin
        hi_pick = first_set(elig_i & prio_i);
        lo_pick = first_set(elig_i & ~prio_i);
        if (hi_pick[SRC_W])
        begin
            pick_o = '{valid: 1'b1, high: 1'b1, src: hi_pick[SRC_W-1:0]};
        end
        else
        begin
            // lowest index wins within a level  see R16
            pick_o = '{valid: lo_pick[SRC_W], high: 1'b0, src: lo_pick[SRC_W-1:0]};
        end
    end

endmodule

// File: logic/mid_dispatch.sv
/*
 Interrupt dispatch for a small microcontroller: pending flags, enables,
 priorities and the request handshake toward the instruction sequencer.
 Assumes the core signals instruction boundaries, vector acceptance and
 the end of each return_from_interrupt; the register port is synchronous.
*/
// Function
// R01: Up to fifteen sources are held, each with a low or high priority level.
// R02: A source's condition pulse sets its pending flag to one.
// R03: A flag is set by its condition whether the source is enabled or not.
// R04: An enabled source raises a request as soon as its flag is set.
// R05: After the current instruction ends a long_call is made to the source's fixed vector.
// R06: Each routine ends with return_from_interrupt and execution resumes where it left off.
// R07: A flag of a disabled source has no effect on program flow.
// R08: Each source has its own enable bit and is considered only when it is set.
// R09: Individual enables work only while global_irq_enable is one.
// R10: Clearing global_irq_enable blocks every source.
// R11: Designated sources have their flag cleared by hardware when the core vectors.
// R12: Software clears the other flags before the return.
// R13: A flag still set after the return requests again after one more instruction.
// R14: High priority preempts a low routine, a high routine is never preempted, low is default.
// R15: Requests are sampled each clock; best response is one detect cycle plus four call cycles.
// R16: Equal-level requests are arbitrated in a fixed per-source order.
// R17: A software write that sets a pending flag acts exactly like a hardware set.
module mid_dispatch
    import mid_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    input  wire logic [NUM_SRC-1:0] src_event_i,
    input  wire logic [NUM_SRC-1:0] sw_clear_i,
    input  mid_sfr_req_s            sfr_i,
    input  wire logic               insn_done_i,
    input  wire logic               vector_ack_i,
    input  wire logic               return_from_interrupt_done_i,
    output logic [7:0]              sfr_rdata_o,
    output logic                    irq_req_o,
    output logic [SRC_W-1:0]        irq_src_o,
    output logic                    long_call_o,
    output logic [NUM_SRC-1:0]      pending_o,
    output logic [7:0]              ext_pin_irq_config_o
);

    logic [7:0]         irq_enable_main_r,    irq_enable_main_nxt;
    logic [7:0]         irq_priority_main_r,  irq_priority_main_nxt;
    logic [7:0]         ext_pin_irq_config_r, ext_pin_irq_config_nxt;
    logic [7:0]         irq_enable_ext_1_r,   irq_enable_ext_1_nxt;
    logic [7:0]         irq_enable_ext_2_r,   irq_enable_ext_2_nxt;
    logic [7:0]         irq_priority_ext_1_r, irq_priority_ext_1_nxt;
    logic [7:0]         irq_priority_ext_2_r, irq_priority_ext_2_nxt;
    logic [NUM_SRC-1:0] pend_r,               pend_nxt;
    logic [7:0]         rdata_r,              rdata_nxt;

    logic [NUM_SRC-1:0] en_vec;
    logic [NUM_SRC-1:0] pri_vec;
    logic [NUM_SRC-1:0] elig;
    logic               global_irq_enable;
    mid_req_s           pick;

    always_comb
    begin
        en_vec  = {irq_enable_ext_2_r[EXT2_SRC_CNT-1:0],
                   irq_enable_ext_1_r[EXT1_SRC_CNT-1:0],
                   irq_enable_main_r[MAIN_SRC_CNT-1:0]};                     // see R08
        pri_vec = {irq_priority_ext_2_r[EXT2_SRC_CNT-1:0],
                   irq_priority_ext_1_r[EXT1_SRC_CNT-1:0],
                   irq_priority_main_r[MAIN_SRC_CNT-1:0]};                   // see R01
        global_irq_enable = irq_enable_main_r[GLOBAL_EN_BIT];
    end

    // dispatch sequencer
    mid_state_e         state_r,     state_nxt;
    logic               act_lo_r,    act_lo_nxt;
    logic               act_hi_r,    act_hi_nxt;
    logic               skip_r,      skip_nxt;
    logic               cur_hi_r,    cur_hi_nxt;
    logic [SRC_W-1:0]   src_r,       src_nxt;
    logic [2:0]         cnt_r,       cnt_nxt;
    logic               req_r,       req_nxt;
    logic               call_r,      call_nxt;
    logic               vec_clr;

    always_comb
    begin
        // nothing enters while a high routine runs; low routine only yields to high
        elig = pend_r & en_vec & {NUM_SRC{global_irq_enable}};              // see R07, R09, R10
        if (act_hi_r)
        begin
            elig = '0;                                                       // see R14
        end
        else if (act_lo_r)
        begin
            elig = elig & pri_vec;                                           // see R14
        end
    end

    mid_arbiter #(
        .N      (NUM_SRC)
    ) u_arb (
        .elig_i (elig),
        .prio_i (pri_vec),
        .pick_o (pick)
    );

    always_comb
    begin
        state_nxt  = state_r;
        act_lo_nxt = act_lo_r;
        act_hi_nxt = act_hi_r;
        skip_nxt   = skip_r;
        cur_hi_nxt = cur_hi_r;
        src_nxt    = src_r;
        cnt_nxt    = cnt_r;
        req_nxt    = 1'b0;
        call_nxt   = 1'b0;
        vec_clr    = 1'b0;
        if (return_from_interrupt_done_i)
        begin
            // leave innermost level; one instruction must run before re-entry
            if (act_hi_r)
            begin
                act_hi_nxt = 1'b0;
            end
            else
            begin
                act_lo_nxt = 1'b0;
            end
            skip_nxt = 1'b1;                                                 // see R06, R13
        end
        case (state_r)
            MID_IDLE:
            begin
                if (pick.valid && !skip_r && !return_from_interrupt_done_i)
                begin
                    state_nxt  = MID_WAIT_INSN;                              // see R04, R15
                    src_nxt    = pick.src;
                    cur_hi_nxt = pick.high;
                    req_nxt    = 1'b1;
                end
                else if (skip_r && insn_done_i)
                begin
                    skip_nxt = 1'b0;                                         // see R13
                end
            end
            MID_WAIT_INSN:
            begin
                req_nxt = 1'b1;
                if (!pick.valid)
                begin
                    state_nxt = MID_IDLE;
                    req_nxt   = 1'b0;
                end
                else if (insn_done_i)
                begin
                    state_nxt = MID_CALL;                                    // see R05
                    cnt_nxt   = CALL_CNT;
                    req_nxt   = 1'b0;
                    call_nxt  = 1'b1;
                    vec_clr   = AUTO_CLR_MASK[src_r];                        // see R11
                    if (cur_hi_r)
                    begin
                        act_hi_nxt = 1'b1;
                    end
                    else
                    begin
                        act_lo_nxt = 1'b1;
                    end
                end
                else
                begin
                    src_nxt    = pick.src;                                   // see R16
                    cur_hi_nxt = pick.high;
                end
            end
            MID_CALL:
            begin
                call_nxt = 1'b1;
                cnt_nxt  = cnt_r - 3'h1;
                if (cnt_r == 3'h1)
                begin
                    state_nxt = MID_HOLD;                                    // see R15
                end
            end
            MID_HOLD:
            begin
                if (vector_ack_i || cnt_r == 3'h0)
                begin
                    state_nxt = MID_IDLE;
                end
            end
            default:
            begin
                state_nxt = MID_IDLE;
            end
        endcase
    end

    always_comb
    begin
        irq_enable_main_nxt    = irq_enable_main_r;
        irq_priority_main_nxt  = irq_priority_main_r;
        ext_pin_irq_config_nxt = ext_pin_irq_config_r;
        irq_enable_ext_1_nxt   = irq_enable_ext_1_r;
        irq_enable_ext_2_nxt   = irq_enable_ext_2_r;
        irq_priority_ext_1_nxt = irq_priority_ext_1_r;
        irq_priority_ext_2_nxt = irq_priority_ext_2_r;
        pend_nxt               = pend_r & ~sw_clear_i;                       // see R12
        if (vec_clr)
        begin
            pend_nxt[src_r] = 1'b0;                                          // see R11
        end
        if (sfr_i.wr)
        begin
            case (sfr_i.addr)
                ADDR_EN_MAIN:  irq_enable_main_nxt    = sfr_i.wdata;
                ADDR_PRI_MAIN: irq_priority_main_nxt  = sfr_i.wdata;
                ADDR_EXT_CFG:  ext_pin_irq_config_nxt = sfr_i.wdata;
                ADDR_EN_EXT1:  irq_enable_ext_1_nxt   = sfr_i.wdata;
                ADDR_EN_EXT2:  irq_enable_ext_2_nxt   = sfr_i.wdata;
                ADDR_PRI_EXT1: irq_priority_ext_1_nxt = sfr_i.wdata;
                ADDR_PRI_EXT2: irq_priority_ext_2_nxt = sfr_i.wdata;
                ADDR_PEND_LO:  pend_nxt = {pend_nxt[14:8], sfr_i.wdata};     // see R17
                ADDR_PEND_HI:  pend_nxt = {sfr_i.wdata[6:0], pend_nxt[7:0]}; // see R17
                default:       pend_nxt = pend_nxt;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        pend_nxt = pend_nxt | src_event_i;                                   // see R02, R03

        rdata_nxt = rdata_r;
        if (sfr_i.rd)
        begin
            case (sfr_i.addr)
                ADDR_EN_MAIN:  rdata_nxt = irq_enable_main_r;
                ADDR_PRI_MAIN: rdata_nxt = irq_priority_main_r;
                ADDR_EXT_CFG:  rdata_nxt = ext_pin_irq_config_r;
                ADDR_EN_EXT1:  rdata_nxt = irq_enable_ext_1_r;
                ADDR_EN_EXT2:  rdata_nxt = irq_enable_ext_2_r;
                ADDR_PRI_EXT1: rdata_nxt = irq_priority_ext_1_r;
                ADDR_PRI_EXT2: rdata_nxt = irq_priority_ext_2_r;
                ADDR_PEND_LO:  rdata_nxt = pend_r[7:0];
                ADDR_PEND_HI:  rdata_nxt = {1'b0, pend_r[14:8]};
                ADDR_ACTIVE:   rdata_nxt = {5'h00, skip_r, act_hi_r, act_lo_r};
                default:       rdata_nxt = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            irq_enable_main_r    <= REG_RESET;
            irq_priority_main_r  <= REG_RESET;                               // see R14
            ext_pin_irq_config_r <= REG_RESET;
            irq_enable_ext_1_r   <= REG_RESET;
            irq_enable_ext_2_r   <= REG_RESET;
            irq_priority_ext_1_r <= REG_RESET;
            irq_priority_ext_2_r <= REG_RESET;
            pend_r               <= '0;
            rdata_r              <= REG_RESET;
            state_r              <= MID_IDLE;
            act_lo_r             <= 1'b0;
            act_hi_r             <= 1'b0;
            skip_r               <= 1'b0;
            cur_hi_r             <= 1'b0;
            src_r                <= '0;
            cnt_r                <= '0;
            req_r                <= 1'b0;
            call_r               <= 1'b0;
        end
        else
        begin
            irq_enable_main_r    <= irq_enable_main_nxt;
            irq_priority_main_r  <= irq_priority_main_nxt;
            ext_pin_irq_config_r <= ext_pin_irq_config_nxt;
            irq_enable_ext_1_r   <= irq_enable_ext_1_nxt;
            irq_enable_ext_2_r   <= irq_enable_ext_2_nxt;
            irq_priority_ext_1_r <= irq_priority_ext_1_nxt;
            irq_priority_ext_2_r <= irq_priority_ext_2_nxt;
            pend_r               <= pend_nxt;
            rdata_r              <= rdata_nxt;
            state_r              <= state_nxt;
            act_lo_r             <= act_lo_nxt;
            act_hi_r             <= act_hi_nxt;
            skip_r               <= skip_nxt;
            cur_hi_r             <= cur_hi_nxt;
            src_r                <= src_nxt;
            cnt_r                <= cnt_nxt;
            req_r                <= req_nxt;
            call_r               <= call_nxt;
        end
    end

    always_comb
    begin
        sfr_rdata_o          = rdata_r;
        irq_req_o            = req_r;
        irq_src_o            = src_r;
        long_call_o          = call_r;
        pending_o            = pend_r;
        ext_pin_irq_config_o = ext_pin_irq_config_r;
    end

endmodule

// File: testbench/mid_dispatch_props.sv
/*
 Checker for mid_dispatch: flag setting, request gating and call timing.
 Assumes the top ports only, one clock domain, synchronous active-low reset.
*/
module mid_dispatch_props
    import mid_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    input  wire logic [NUM_SRC-1:0] src_event_i,
    input  wire logic [NUM_SRC-1:0] sw_clear_i,
    input  mid_sfr_req_s            sfr_i,
    input  wire logic               insn_done_i,
    input  wire logic               vector_ack_i,
    input  wire logic               return_from_interrupt_done_i,
    input  wire logic [7:0]         sfr_rdata_o,
    input  wire logic               irq_req_o,
    input  wire logic [SRC_W-1:0]   irq_src_o,
    input  wire logic               long_call_o,
    input  wire logic [NUM_SRC-1:0] pending_o,
    input  wire logic [7:0]         ext_pin_irq_config_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic glob_r;
    logic glob_nxt;

    // shadow of the global enable bit
    always_comb
    begin
        glob_nxt = glob_r;
        if (sfr_i.wr && sfr_i.addr == ADDR_EN_MAIN)
            glob_nxt = sfr_i.wdata[GLOBAL_EN_BIT];
    end

    always_ff @(posedge clock_i)
        glob_r <= resetn_i ? glob_nxt : 1'b0;

    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    AST_EVENT_SETS: assert property (
        (src_event_i != '0) |=> ((pending_o & $past(src_event_i)) == $past(src_event_i)))
        else $error("event did not set its flag");
    AST_SW_SET: assert property (
        (sfr_i.wr && sfr_i.addr == ADDR_PEND_LO)
        |=> ((pending_o[7:0] & $past(sfr_i.wdata)) == $past(sfr_i.wdata)))
        else $error("register write did not set flags");
    AST_SW_CLR: assert property (
        ((sw_clear_i & ~src_event_i) != '0 && !sfr_i.wr)
        |=> ((pending_o & $past(sw_clear_i) & ~$past(src_event_i)) == '0))
        else $error("software clear ignored");
    AST_GLOBAL_OFF: assert property (
        !glob_r |=> !$rose(irq_req_o))
        else $error("request raised with global enable off");
    AST_REQ_CAUSE: assert property (
        $rose(irq_req_o) |-> (($past(pending_o) >> irq_src_o) & 15'h1) != '0)
        else $error("request without a pending flag");
    AST_CALL_AFTER_INSN: assert property (
        (irq_req_o && insn_done_i && glob_r && pending_o[irq_src_o])
        |=> $rose(long_call_o) && !irq_req_o)
        else $error("no call after instruction end");
    AST_CALL_LEN: assert property (
        $rose(long_call_o) |-> long_call_o [*4] ##1 !long_call_o)
        else $error("call length wrong");
    AST_AUTO_CLR: assert property (
        ($rose(long_call_o) && AUTO_CLR_MASK[irq_src_o]
         && (($past(src_event_i) >> irq_src_o) & 15'h1) == '0) |-> !pending_o[irq_src_o])
        else $error("flag not cleared on vectoring");
    AST_KEEP_FLAG: assert property (
        ($rose(long_call_o) && !AUTO_CLR_MASK[irq_src_o]
         && (($past(sw_clear_i) >> irq_src_o) & 15'h1) == '0) |-> pending_o[irq_src_o])
        else $error("flag cleared by hardware");
    AST_RETURN_FROM_INTERRUPT_GAP: assert property (
        return_from_interrupt_done_i |=> !$rose(long_call_o))
        else $error("call directly after return");

    COV_CALL: cover property ($rose(long_call_o));
    COV_REENTRY: cover property (return_from_interrupt_done_i && pending_o != '0);
    COV_HIGH_PICK: cover property (irq_req_o && irq_src_o == 4'h4);
endmodule

bind mid_dispatch mid_dispatch_props i_mid_dispatch_props (
    .clock_i(clock_i), .resetn_i(resetn_i), .src_event_i(src_event_i),
    .sw_clear_i(sw_clear_i), .sfr_i(sfr_i), .insn_done_i(insn_done_i),
    .vector_ack_i(vector_ack_i), .return_from_interrupt_done_i(return_from_interrupt_done_i), .sfr_rdata_o(sfr_rdata_o),
    .irq_req_o(irq_req_o), .irq_src_o(irq_src_o), .long_call_o(long_call_o),
    .pending_o(pending_o), .ext_pin_irq_config_o(ext_pin_irq_config_o));

// File: testbench/mid_core_model.sv
/*
 Behavioural model of the instruction sequencer facing the dispatch block.
 Assumes insn_len 0 stalls the core; tracks one routine source only.
*/
module mid_core_model
    import mid_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    input  wire logic               long_call_i,
    input  wire logic [SRC_W-1:0]   src_i,
    input  wire logic [3:0]         insn_len_i,
    input  wire logic [3:0]         isr_len_i,
    input  wire logic               sw_clr_en_i,
    output logic                    insn_done_o = 1'b0,
    output logic                    vector_ack_o = 1'b0,
    output logic                    return_from_interrupt_done_o = 1'b0,
    output logic [NUM_SRC-1:0]      sw_clear_o = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    int               cnt;
    int               left;
    int               depth;
    logic [SRC_W-1:0] svc;
    logic             call_q;

    always @(posedge clock_i)
    begin
        insn_done_o <= 1'b0;
        vector_ack_o <= 1'b0;
        return_from_interrupt_done_o <= 1'b0;
        sw_clear_o <= '0;
        call_q <= long_call_i;
        if (long_call_i && !call_q)
            svc <= src_i;
        if (!resetn_i)
        begin
            cnt <= 0;
            depth <= 0;
        end
        else if (call_q && !long_call_i)
        begin
            vector_ack_o <= 1'b1;
            depth <= depth + 1;
            left <= isr_len_i;
            cnt <= 0;
        end
        else if (!long_call_i && insn_len_i != 0)
        begin
            cnt <= (cnt + 1 >= insn_len_i) ? 0 : cnt + 1;
            if (cnt + 1 >= insn_len_i && depth != 0 && left == 0)
            begin
                return_from_interrupt_done_o <= 1'b1;
                depth <= depth - 1;
                left <= isr_len_i;
            end
            else if (cnt + 1 >= insn_len_i)
            begin
                insn_done_o <= 1'b1;
                left <= (depth != 0) ? left - 1 : left;
                // clear before the return when enabled
                if (depth != 0 && left == 1 && sw_clr_en_i && !AUTO_CLR_MASK[svc])
                    sw_clear_o[svc] <= 1'b1;
            end
        end
    end
endmodule

// File: testbench/tb_mid_dispatch.sv
/*
 Self-checking bench for mid_dispatch with a core model on the far side.
 Assumes the checker is bound to the design; 100 ns clock.
*/
module tb_mid_dispatch
    import mid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] en2;
        logic       sw;
        logic [3:0] src;
        logic       req;
    } mid_row_s;
    localparam mid_row_s ROWS [8] = '{'{8'h81, 8'h00, 8'h00, 1'b0, 4'h0, 1'b1},
        '{8'h01, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0}, '{8'h80, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
        '{8'h80, 8'h20, 8'h00, 1'b0, 4'hc, 1'b1}, '{8'h80, 8'h00, 8'h02, 1'b0, 4'he, 1'b1},
        '{8'h7f, 8'h3f, 8'h03, 1'b0, 4'h9, 1'b0}, '{8'h80, 8'h3f, 8'h00, 1'b0, 4'hd, 1'b0},
        '{8'h80, 8'h02, 8'h00, 1'b1, 4'h8, 1'b1}};
    localparam logic [15:0] REGS [7] = '{{ADDR_EN_MAIN, 8'h2a}, {ADDR_PRI_MAIN, 8'h2a},
        {ADDR_EXT_CFG, 8'h5a}, {ADDR_EN_EXT1, 8'h2a}, {ADDR_EN_EXT2, 8'h02},
        {ADDR_PRI_EXT1, 8'h2a}, {ADDR_PRI_EXT2, 8'h02}};
    logic               clock_i = 1'b0;
    logic               resetn_i = 1'b0;
    logic [NUM_SRC-1:0] src_event = '0;
    mid_sfr_req_s       sfr = '0;
    logic [3:0]         insn_len = 4'h0;
    logic [3:0]         isr_len = 4'h2;
    logic               sw_clr_en = 1'b0;
    logic               insn_done, vector_ack, return_from_interrupt_done, irq_req, long_call;
    logic [NUM_SRC-1:0] sw_clear, pending;
    logic [7:0]         rdata, cfg;
    logic [SRC_W-1:0]   irq_src;
    int                 miscompares = 0;
    int                 n_checks = 0;
    int                 n;

    always #50 clock_i = ~clock_i;

    mid_dispatch i_mid_dispatch (.clock_i(clock_i), .resetn_i(resetn_i),
        .src_event_i(src_event), .sw_clear_i(sw_clear), .sfr_i(sfr),
        .insn_done_i(insn_done), .vector_ack_i(vector_ack), .return_from_interrupt_done_i(return_from_interrupt_done),
        .sfr_rdata_o(rdata), .irq_req_o(irq_req), .irq_src_o(irq_src),
        .long_call_o(long_call), .pending_o(pending), .ext_pin_irq_config_o(cfg));
    mid_core_model i_mid_core_model (.clock_i(clock_i), .resetn_i(resetn_i),
        .long_call_i(long_call), .src_i(irq_src), .insn_len_i(insn_len),
        .isr_len_i(isr_len), .sw_clr_en_i(sw_clr_en), .insn_done_o(insn_done),
        .vector_ack_o(vector_ack), .return_from_interrupt_done_o(return_from_interrupt_done), .sw_clear_o(sw_clear));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sfr_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        sfr <= '{w, !w, a, d};
        @(posedge clock_i);
        sfr <= '0;
        #1;
    endtask

    task automatic pulse(input logic [NUM_SRC-1:0] v);
        @(posedge clock_i);
        src_event <= v;
        @(posedge clock_i);
        src_event <= '0;
        #1;
    endtask

    // rising edges of long_call over a fixed window
    task automatic count_calls(output int rises);
        logic prev;
        rises = 0;
        prev = long_call;
        repeat (60)
        begin
            @(posedge clock_i);
            #1;
            rises += (long_call && !prev) ? 1 : 0;
            prev = long_call;
        end
    endtask

    task automatic set_core(input logic [3:0] len, input logic clr);
        @(posedge clock_i);
        insn_len <= len;
        sw_clr_en <= clr;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clock_i);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        check({irq_req, long_call, pending}, 16'h0000);
        foreach (REGS[i])
        begin
            sfr_op(1'b0, REGS[i][15:8], 8'h00);
            check(rdata, REG_RESET);
            sfr_op(1'b1, REGS[i][15:8], REGS[i][7:0]);
            sfr_op(1'b0, REGS[i][15:8], 8'h00);
            check(rdata, REGS[i][7:0]);
            sfr_op(1'b1, REGS[i][15:8], 8'h00);
        end
        sfr_op(1'b1, ADDR_EXT_CFG, 8'h5a);
        check(cfg, 8'h5a);
        sfr_op(1'b1, 8'ha9, 8'hff);
        sfr_op(1'b0, 8'ha9, 8'h00);
        check(rdata, 8'h00);
        foreach (ROWS[i])
        begin
            sfr_op(1'b1, ADDR_EN_MAIN, ROWS[i].en0);
            sfr_op(1'b1, ADDR_EN_EXT1, ROWS[i].en1);
            sfr_op(1'b1, ADDR_EN_EXT2, ROWS[i].en2);
            if (ROWS[i].sw)
                sfr_op(1'b1, ROWS[i].src[3] ? ADDR_PEND_HI : ADDR_PEND_LO,
                       8'h01 << ROWS[i].src[2:0]);
            else
                pulse(15'h1 << ROWS[i].src);
            check(pending, 15'h1 << ROWS[i].src);
            @(posedge clock_i);
            #1;
            check({irq_req, irq_src & {4{irq_req}}}, {ROWS[i].req, ROWS[i].src & {4{ROWS[i].req}}});
            sfr_op(1'b1, ADDR_EN_MAIN, 8'h00);
            sfr_op(1'b1, ADDR_PEND_LO, 8'h00);
            sfr_op(1'b1, ADDR_PEND_HI, 8'h00);
        end
        sfr_op(1'b1, ADDR_EN_MAIN, 8'hb2);
        set_core(4'h1, 1'b1);
        pulse(15'h0002);
        n = 0;
        while (long_call !== 1'b1 && n < 50)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(n, 2);
        check(pending[1], 1'b0);
        set_core(4'h1, 1'b0);
        pulse(15'h0020);
        count_calls(n);
        check(n >= 2, 1'b1);
        sfr_op(1'b1, ADDR_EN_MAIN, 8'h00);
        sfr_op(1'b1, ADDR_PEND_LO, 8'h00);
        set_core(4'h1, 1'b1);
        count_calls(n);
        check(n, 0);
        sfr_op(1'b1, ADDR_EN_MAIN, 8'hbf);
        sfr_op(1'b1, ADDR_PRI_MAIN, 8'h10);
        set_core(4'h0, 1'b1);
        pulse(15'h000c);
        @(posedge clock_i);
        #1;
        check(irq_src, 4'h2);
        pulse(15'h0010);
        @(posedge clock_i);
        #1;
        check(irq_src, 4'h4);
        set_core(4'h1, 1'b1);
        count_calls(n);
        check(n, 3);
        check(pending, 15'h0000);
        sfr_op(1'b1, ADDR_PEND_LO, 8'hff);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        check({irq_req, long_call, pending}, 16'h0000);
        sfr_op(1'b0, ADDR_EN_MAIN, 8'h00);
        check(rdata, REG_RESET);
        tally_and_finish();
    end
endmodule
